// ### rtl/nfcomc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "nfcomc_defs.svh"
module nfcomc_top
  import nfcomc_pkg::*;
(
  // Clock and resets
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic por_n_i,
  // Register port
  input wire nfcomc_bus_t bus_i,
  output logic [7:0] rdata_o,
  // Crystal-stable level from the oscillator
  input wire logic osc_ok_i,
  // Events from the sequencer, same clock
  input wire logic field_on_i,
  input wire logic tx_done_i,
  // Channel choice from receiver configuration, 0 AM, 1 PM
  input wire logic receiver_channel_choice_i,
  // Decoded enables toward the RF paths
  output nfcomc_rf_t rf_o
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] opc_r; // Operation control register
  logic [7:0] mode_r; // Mode definition register
  logic osc_ok_s; // Synchronised crystal-stable flag
  logic wr_opc; // Write to operation control
  logic wr_mode; // Write to mode definition
  logic mode_wr_ok; // Mode write accepted
  logic act_mode; // Active peer mode selected
  logic [7:0] stat_w; // Status read value
  logic [7:0] rdata_nxt; // Read data for next cycle
  nfcomc_rf_t rf_nxt; // Decoded enables, next value
  nfcomc_mode_t mode_dec; // Decoded operating mode
  logic [3:0] om_w; // Operating-mode field of the mode register

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Operating-mode decode for either role
  function automatic nfcomc_mode_t decode_mode(
    input logic targ,
    input logic [3:0] om
  );
    nfcomc_mode_t m;
    m = NFCOMC_M_NONE;
    if (!targ)
    begin
      // Initiator codes
      unique case (om)
        `NFCOMC_OM_ACT: m = NFCOMC_M_ACT_I;
        `NFCOMC_OM_A: m = NFCOMC_M_A;
        `NFCOMC_OM_B: m = NFCOMC_M_B;
        `NFCOMC_OM_F: m = NFCOMC_M_F;
        `NFCOMC_OM_T1: m = NFCOMC_M_T1;
        `NFCOMC_OM_SUB: m = NFCOMC_M_SUB;
        `NFCOMC_OM_BPSK: m = NFCOMC_M_BPSK;
        default: m = NFCOMC_M_NONE; // Reserved codes
      endcase
    end
    else if (om[`NFCOMC_OM_BRD])
    begin
      // Bit-rate detection, reserved bit must be clear
      if (!om[`NFCOMC_OM_BRD_R])
        m = NFCOMC_M_BRD;
    end
    else
    begin
      // Target codes below the detection range
      unique case (om)
        `NFCOMC_TOM_A: m = NFCOMC_M_PT_A;
        `NFCOMC_TOM_F: m = NFCOMC_M_PT_F;
        `NFCOMC_TOM_ACT: m = NFCOMC_M_ACT_T;
        default: m = NFCOMC_M_NONE; // Not allowed
      endcase
    end
    return m;
  endfunction

  // Active peer communication in either role
  function automatic logic is_active(input nfcomc_mode_t m);
    return (m == NFCOMC_M_ACT_I) || (m == NFCOMC_M_ACT_T);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Crystal-stable flag crossing in from the oscillator
  nfcomc_sync #(
    .W(1)
  ) u_osc_sync (
    .clk_i(core_clk_i),
    .rstn_i(resetn_i),
    .d_i(osc_ok_i),
    .q_o(osc_ok_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wr_opc = bus_i.wr && (bus_i.addr == `NFCOMC_OPC_ADDR);
  assign wr_mode = bus_i.wr && (bus_i.addr == `NFCOMC_MODE_ADDR);
  // Mode register only takes data with a stable crystal
  assign mode_wr_ok = wr_mode && osc_ok_s;
  assign mode_dec = decode_mode(mode_r[`NFCOMC_MODE_TARG],
                                mode_r[`NFCOMC_MODE_OM]);
  assign act_mode = is_active(mode_dec);
  assign om_w = mode_r[`NFCOMC_MODE_OM];

  ////////////////////////////////////////////////////////////////////////
  // Operation control register
  // Cleared by power-up only; a plain reset leaves it alone
  always_ff @(posedge core_clk_i or negedge por_n_i)
  begin
    if (!por_n_i)
      opc_r <= `NFCOMC_OPC_RST;
    else
    begin
      // Software write first, hardware events override
      if (wr_opc)
        opc_r <= bus_i.wdata;
      if (field_on_i)
        opc_r[`NFCOMC_OPC_TXEN] <= 1'b1;
      else if (tx_done_i && act_mode)
        opc_r[`NFCOMC_OPC_TXEN] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode definition register
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      mode_r <= `NFCOMC_MODE_RST;
    else if (mode_wr_ok)
      mode_r <= bus_i.wdata;
    // Writes without a stable crystal fall through
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode of both registers into path enables
  always_comb
  begin
    rf_nxt = '0;
    // Oscillator and regulator, ready once the crystal settles
    rf_nxt.osc_en = opc_r[`NFCOMC_OPC_EN];
    rf_nxt.ready = opc_r[`NFCOMC_OPC_EN] && osc_ok_s;
    // Role and operating mode
    rf_nxt.target = mode_r[`NFCOMC_MODE_TARG];
    rf_nxt.mode = mode_dec;
    rf_nxt.mode_ok = (mode_dec != NFCOMC_M_NONE);
    // Detection enables only in bit-rate detection mode
    if (mode_dec == NFCOMC_M_BRD)
    begin
      rf_nxt.brd_f = om_w[`NFCOMC_OM_BRD_F];
      rf_nxt.brd_a = om_w[`NFCOMC_OM_BRD_A];
    end
    // Receive path, dropped on an unsupported mode
    rf_nxt.rx_en = opc_r[`NFCOMC_OPC_RXEN] && rf_nxt.mode_ok;
    if (rf_nxt.rx_en)
    begin
      if (opc_r[`NFCOMC_OPC_RXCHN])
      begin
        // One channel, picked by the receiver setting
        rf_nxt.am_en = !receiver_channel_choice_i;
        rf_nxt.pm_en = receiver_channel_choice_i;
      end
      else
      begin
        // Both channels, automatic or manual summation
        rf_nxt.am_en = 1'b1;
        rf_nxt.pm_en = 1'b1;
        rf_nxt.auto_chan = !opc_r[`NFCOMC_OPC_RXMAN];
      end
    end
    // Transmit, dropped on an unsupported mode
    rf_nxt.tx_en = opc_r[`NFCOMC_OPC_TXEN] && rf_nxt.mode_ok;
    rf_nxt.wakeup = opc_r[`NFCOMC_OPC_WU];
    rf_nxt.fd_mode = nfcomc_fd_t'(opc_r[`NFCOMC_OPC_FD]);
    // Detector alone on selects the low-power initial state
    rf_nxt.lp_init = (opc_r[`NFCOMC_OPC_FD] != 2'h0) &&
                     (opc_r[`NFCOMC_OPC_REST] == 6'h00);
    rf_nxt.mod_am = mode_r[`NFCOMC_MODE_AM];
    rf_nxt.resp = nfcomc_ar_t'(mode_r[`NFCOMC_MODE_AR]);
  end

  // Registered enables
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rf_o <= '0;
    else
      rf_o <= rf_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path
  assign stat_w = {5'h00, rf_nxt.lp_init, rf_nxt.mode_ok, osc_ok_s};

  // Read mux, unmapped addresses give zero
  always_comb
  begin
    rdata_nxt = `NFCOMC_ZERO8;
    if (bus_i.rd)
    begin
      unique case (bus_i.addr)
        `NFCOMC_OPC_ADDR: rdata_nxt = opc_r;
        `NFCOMC_MODE_ADDR: rdata_nxt = mode_r;
        `NFCOMC_STAT_ADDR: rdata_nxt = stat_w;
        default: rdata_nxt = `NFCOMC_ZERO8;
      endcase
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_o <= `NFCOMC_ZERO8;
    else
      rdata_o <= rdata_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Blocked mode write: strobe while the crystal is unstable
  sequence s_mode_blocked;
    wr_mode && !osc_ok_s;
  endsequence

  // Accepted mode write
  sequence s_mode_taken;
    wr_mode && osc_ok_s;
  endsequence

  // Hardware done event in active mode without a competing set
  sequence s_tx_finish;
    tx_done_i && act_mode && !field_on_i;
  endsequence

  // Ready follows the enable once the crystal is settled
  a_osc_ready: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    opc_r[`NFCOMC_OPC_EN] && osc_ok_s |=> rf_o.osc_en && rf_o.ready)
    else $error("oscillator or ready not raised");

  // Receive enables stay low while receive is off
  a_rx_gate: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !opc_r[`NFCOMC_OPC_RXEN] |=> !rf_o.rx_en && !rf_o.am_en && !rf_o.pm_en)
    else $error("receive active while disabled");

  // Enables lag one cycle behind a plain reset release, hence resetn_i
  // in the antecedents that compare against control bits kept over reset
  // Single channel follows the receiver choice
  a_single_chan: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    resetn_i && opc_r[`NFCOMC_OPC_RXEN] && opc_r[`NFCOMC_OPC_RXCHN] &&
    rf_nxt.mode_ok
    |=> (rf_o.am_en != rf_o.pm_en) && (rf_o.pm_en == $past(
      receiver_channel_choice_i)))
    else $error("single channel selection wrong");

  // Both channels on, method from the manual bit
  a_auto_chan: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    resetn_i && rf_nxt.rx_en && !opc_r[`NFCOMC_OPC_RXCHN]
    |=> rf_o.am_en && rf_o.pm_en &&
        (rf_o.auto_chan == !$past(opc_r[`NFCOMC_OPC_RXMAN])))
    else $error("channel method wrong");

  // Field-on always leaves transmit set
  a_tx_set_wins: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    field_on_i |=> opc_r[`NFCOMC_OPC_TXEN])
    else $error("field-on did not set transmit");

  // Done in an active peer mode clears transmit
  a_tx_done_clr: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    s_tx_finish |=> !opc_r[`NFCOMC_OPC_TXEN] ##1 !rf_o.tx_en)
    else $error("transmit not cleared after done");

  // Wake-up output follows a rise of its control bit
  a_wakeup_out: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    $rose(opc_r[`NFCOMC_OPC_WU]) |=> rf_o.wakeup)
    else $error("wake-up not entered");

  // Detector code passed through unchanged
  a_fd_decode: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    resetn_i |=> rf_o.fd_mode == nfcomc_fd_t'($past(opc_r[`NFCOMC_OPC_FD])))
    else $error("field detector decode wrong");

  // Detector alone gives the low-power initial state
  a_low_power: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    resetn_i && (opc_r[`NFCOMC_OPC_FD] == 2'h3) &&
    (opc_r[`NFCOMC_OPC_REST] == 6'h00)
    |=> rf_o.lp_init && !rf_o.osc_en)
    else $error("low-power state missed");

  // Plain reset leaves operation control alone
  a_opc_keeps: assert property (
    @(posedge core_clk_i) disable iff (!por_n_i)
    !resetn_i && !bus_i.wr && !field_on_i && !tx_done_i |=> $stable(opc_r))
    else $error("control lost on plain reset");

  // Initiator code for type B
  a_init_typeb: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !mode_r[`NFCOMC_MODE_TARG] && mode_r[`NFCOMC_MODE_OM] == `NFCOMC_OM_B
    |=> rf_o.mode == NFCOMC_M_B && !rf_o.target)
    else $error("initiator decode wrong");

  // Target code for active peer communication
  a_targ_active: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    mode_r[`NFCOMC_MODE_TARG] && mode_r[`NFCOMC_MODE_OM] == `NFCOMC_TOM_ACT
    |=> rf_o.mode == NFCOMC_M_ACT_T && rf_o.target)
    else $error("target decode wrong");

  // Unsupported code silences both paths
  a_bad_mode_off: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    mode_dec == NFCOMC_M_NONE |=> !rf_o.tx_en && !rf_o.rx_en)
    else $error("paths on with unsupported mode");

  // Modulation type passed through unchanged
  a_mod_type: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    resetn_i |=> rf_o.mod_am == $past(mode_r[`NFCOMC_MODE_AM]))
    else $error("modulation select wrong");

  // Write with a settled crystal lands
  a_mode_taken: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    s_mode_taken |=> mode_r == $past(bus_i.wdata))
    else $error("accepted mode write lost");

  // Write without a settled crystal is dropped
  a_mode_locked: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    s_mode_blocked |=> $stable(mode_r))
    else $error("mode written without crystal");

  // Read data returns to zero outside its cycle
  a_read_once: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !bus_i.rd |=> rdata_o == `NFCOMC_ZERO8)
    else $error("read data outside its cycle");

endmodule // nfcomc_top
`default_nettype wire

// ### rtl/nfcomc_defs.svh
// How it works
// - Bit 7 starts oscillator, regulator, ready
// - Bit 6 enables receive path
// - Bit 5 picks both or one channel
// - Bit 4 picks automatic or manual selection
// - Bit 3 transmit; field-on sets, done clears in active peer modes only
// - Bit 2 enters wake-up mode
// - Two-bit field detector code decode
// - Operation control defaults at power-up only
// - Mode bit 7 picks initiator or target
// - Initiator operating-mode code decode
// - Target operating-mode code decode
// - Target top bit runs bit-rate detection with the reserved bit clear
// - Unsupported mode disables transmit and receive
// - Mode bit 2 picks OOK or AM
// - Mode writes need stable crystal
`ifndef NFCOMC_DEFS_SVH
`define NFCOMC_DEFS_SVH
// Register offsets
`define NFCOMC_OPC_ADDR 8'h02
`define NFCOMC_MODE_ADDR 8'h03
`define NFCOMC_STAT_ADDR 8'h10
// Reset values
`define NFCOMC_OPC_RST 8'h00
`define NFCOMC_MODE_RST 8'h08
`define NFCOMC_ZERO8 8'h00
// Operation control fields
`define NFCOMC_OPC_EN 7
`define NFCOMC_OPC_RXEN 6
`define NFCOMC_OPC_RXCHN 5
`define NFCOMC_OPC_RXMAN 4
`define NFCOMC_OPC_TXEN 3
`define NFCOMC_OPC_WU 2
`define NFCOMC_OPC_FD 1:0
`define NFCOMC_OPC_REST 7:2
// Mode definition fields
`define NFCOMC_MODE_TARG 7
`define NFCOMC_MODE_OM 6:3
`define NFCOMC_MODE_AM 2
`define NFCOMC_MODE_AR 1:0
// Operating-mode codes, initiator
`define NFCOMC_OM_ACT 4'h0
`define NFCOMC_OM_A 4'h1
`define NFCOMC_OM_B 4'h2
`define NFCOMC_OM_F 4'h3
`define NFCOMC_OM_T1 4'h4
`define NFCOMC_OM_SUB 4'hE
`define NFCOMC_OM_BPSK 4'hF
// Operating-mode codes, target
`define NFCOMC_TOM_A 4'h1
`define NFCOMC_TOM_F 4'h4
`define NFCOMC_TOM_ACT 4'h7
`define NFCOMC_OM_BRD 3
`define NFCOMC_OM_BRD_F 2
`define NFCOMC_OM_BRD_R 1
`define NFCOMC_OM_BRD_A 0
`endif

// ### rtl/nfcomc_pkg.sv
package nfcomc_pkg;
  // Decoded operating mode
  typedef enum logic [3:0] {
    NFCOMC_M_NONE, NFCOMC_M_ACT_I, NFCOMC_M_A, NFCOMC_M_B, NFCOMC_M_F,
    NFCOMC_M_T1, NFCOMC_M_SUB, NFCOMC_M_BPSK, NFCOMC_M_PT_A,
    NFCOMC_M_PT_F, NFCOMC_M_ACT_T, NFCOMC_M_BRD
  } nfcomc_mode_t;
  // Field detector setting
  typedef enum logic [1:0] {
    NFCOMC_FD_OFF, NFCOMC_FD_CA, NFCOMC_FD_PEER, NFCOMC_FD_AUTO
  } nfcomc_fd_t;
  // Auto-response setting
  typedef enum logic [1:0] {
    NFCOMC_AR_OFF, NFCOMC_AR_ANY, NFCOMC_AR_PEER, NFCOMC_AR_RFU
  } nfcomc_ar_t;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } nfcomc_bus_t;
  // Enables toward the RF paths
  typedef struct packed {
    logic osc_en;
    logic ready;
    logic rx_en;
    logic am_en;
    logic pm_en;
    logic auto_chan;
    logic tx_en;
    logic wakeup;
    nfcomc_fd_t fd_mode;
    logic lp_init;
    logic target;
    nfcomc_mode_t mode;
    logic brd_f;
    logic brd_a;
    logic mod_am;
    nfcomc_ar_t resp;
    logic mode_ok;
  } nfcomc_rf_t;
endpackage

// ### rtl/nfcomc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module nfcomc_sync
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Asynchronous level in, filtered level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r; // First stage, read by s2_r only
  logic [W-1:0] s2_r; // Second stage
  logic [W-1:0] s3_r; // Third stage

  //////////////////////////////////////////////////////////////////////
  // Three-stage chain
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Output follows only when stages two and three agree
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q_o <= '0;
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (s2_r[i] == s3_r[i])
          q_o[i] <= s3_r[i];
      end
    end
  end
endmodule // nfcomc_sync
`default_nettype wire

// ### test/nfcomc_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module nfcomc_top_test
  import nfcomc_pkg::*;
  ;
  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic core_clk_i;
  logic resetn_i;
  logic por_n_i;
  logic osc_ok_i;
  logic field_on_i;
  logic tx_done_i;
  logic receiver_channel_choice_i;
  nfcomc_bus_t bus_i;
  logic [7:0] rdata_o;
  nfcomc_rf_t rf_o;
  // Score keeping and reference state
  int err_count;
  int compares;
  integer seed;
  int opc_m;
  int mode_m;
  int osc_m;
  int i;
  ////////////////////////////////////////////////////////////////////////////
  // Device under test
  nfcomc_top u_dut (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .por_n_i(por_n_i),
    .bus_i(bus_i),
    .rdata_o(rdata_o),
    .osc_ok_i(osc_ok_i),
    .field_on_i(field_on_i),
    .tx_done_i(tx_done_i),
    .receiver_channel_choice_i(receiver_channel_choice_i),
    .rf_o(rf_o)
  );
  // 40 MHz clock
  always #12.5 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////////////////////////////////////////
  // Verdict, printed once
  task automatic final_report;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One comparison against the model
  task automatic cmp(input logic [7:0] got, input int exp, input string m);
    compares++;
    if (got !== exp[7:0])
    begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp[7:0]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reference decode of the mode register
  function automatic bit mode_ok_f(input int m);
    int om;
    om = (m >> 3) & 15;
    if (!m[7])
      return om <= 4 || om >= 14;
    return om == 1 || om == 4 || om == 7 || (om >= 8 && !m[4]);
  endfunction
  function automatic nfcomc_mode_t mode_f(input int m);
    int om;
    om = (m >> 3) & 15;
    if (m[7])
      return om >= 8 ? NFCOMC_M_BRD : om == 1 ? NFCOMC_M_PT_A :
        om == 4 ? NFCOMC_M_PT_F : om == 7 ? NFCOMC_M_ACT_T : NFCOMC_M_NONE;
    case (om)
      0: return NFCOMC_M_ACT_I;
      1: return NFCOMC_M_A;
      2: return NFCOMC_M_B;
      3: return NFCOMC_M_F;
      4: return NFCOMC_M_T1;
      14: return NFCOMC_M_SUB;
      15: return NFCOMC_M_BPSK;
      default: return NFCOMC_M_NONE;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Register port master: one-cycle strobes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    bus_i.wr <= 1'b0;
    // Mode writes only land with a settled crystal
    if (a == 8'h02)
      opc_m = d;
    else if (a == 8'h03 && osc_m != 0)
      mode_m = d;
  endtask
  task automatic rd(input logic [7:0] a, input int exp);
    @(posedge core_clk_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    bus_i.rd <= 1'b0;
    #1 cmp(rdata_o, exp, "read data");
    // Read data stands one cycle only
    @(posedge core_clk_i);
    #1 cmp(rdata_o, 0, "read idle");
  endtask
  // Sequencer event pulse: field on or transmission done
  task automatic pulse(input bit done);
    int om;
    @(posedge core_clk_i);
    if (done)
      tx_done_i <= 1'b1;
    else
      field_on_i <= 1'b1;
    @(posedge core_clk_i);
    tx_done_i <= 1'b0;
    field_on_i <= 1'b0;
    om = (mode_m >> 3) & 15;
    if (!done)
      opc_m = opc_m | 8;
    else if ((!mode_m[7] && om == 0) || (mode_m[7] && om == 7))
      opc_m = opc_m & 8'hF7;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Compare every decoded enable one cycle after the register state
  task automatic check_rf;
    bit ok;
    int o;
    int m;
    o = opc_m;
    m = mode_m;
    ok = mode_ok_f(m);
    @(posedge core_clk_i);
    #1 cmp(rf_o.osc_en, o[7], "osc_en");
    cmp(rf_o.ready, o[7] & osc_m[0], "ready");
    cmp(rf_o.rx_en, o[6] & ok, "rx_en");
    cmp(rf_o.tx_en, o[3] & ok, "tx_en");
    cmp(rf_o.wakeup, o[2], "wakeup");
    cmp(rf_o.fd_mode, o & 3, "fd_mode");
    cmp(rf_o.lp_init, (o & 3) != 0 && (o >> 2) == 0, "lp_init");
    cmp(rf_o.mode_ok, ok, "mode_ok");
    cmp(rf_o.target, m[7], "target");
    cmp(rf_o.mod_am, m[2], "mod_am");
    cmp(rf_o.resp, m & 3, "resp");
    // Mode decode only defined for supported codes
    if (ok)
    begin
      cmp(rf_o.mode, mode_f(m), "mode");
      cmp(rf_o.brd_f, m[7] & m[6] & m[5], "brd_f");
      cmp(rf_o.brd_a, m[7] & m[6] & m[3], "brd_a");
    end
    // Channel plan only matters while receiving
    if (o[6] && ok)
    begin
      cmp(rf_o.am_en, !o[5] || !receiver_channel_choice_i, "am");
      cmp(rf_o.pm_en, !o[5] || receiver_channel_choice_i, "pm");
      cmp(rf_o.auto_chan, !o[5] && !o[4], "auto_chan");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial
  begin
    repeat (8000) @(posedge core_clk_i);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report;
  end
  // Main sequence
  initial
  begin
    core_clk_i = 1'b0;
    resetn_i = 1'b0;
    por_n_i = 1'b0;
    osc_ok_i = 1'b0;
    field_on_i = 1'b0;
    tx_done_i = 1'b0;
    receiver_channel_choice_i = 1'b0;
    bus_i = '0;
    err_count = 0;
    compares = 0;
    seed = 20;
    opc_m = 0;
    mode_m = 8'h08;
    osc_m = 0;
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    por_n_i <= 1'b1;
    // Power-up values and an unmapped place
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h08);
    rd(8'h55, 8'h00);
    check_rf;
    // No crystal yet: ready low, mode write dropped
    wr(8'h02, 8'h80);
    wr(8'h03, 8'h88);
    check_rf;
    rd(8'h03, 8'h08);
    rd(8'h10, 8'h02);
    osc_ok_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    osc_m = 1;
    check_rf;
    wr(8'h03, 8'h88);
    rd(8'h03, 8'h88);
    // Every role and operating-mode code, random other bits
    for (i = 0; i < 32; i++)
    begin
      @(posedge core_clk_i);
      receiver_channel_choice_i <= $random(seed);
      wr(8'h02, 8'hC8 | ($random(seed) & 8'h37));
      wr(8'h03, (i << 3) | ($random(seed) & 7));
      check_rf;
    end
    // Operation control codes: detector-only then random
    wr(8'h03, 8'h0C);
    for (i = 0; i < 28; i++)
    begin
      @(posedge core_clk_i);
      receiver_channel_choice_i <= $random(seed);
      wr(8'h02, i < 4 ? i : $random(seed));
      check_rf;
      // Status: crystal, supported mode, low-power state
      rd(8'h10, ((opc_m & 3) != 0 && opc_m < 4) ? 7 : 3);
    end
    // Field-on sets transmit; done clears only in active peer modes
    for (i = 0; i < 3; i++)
    begin
      wr(8'h03, i == 0 ? 8'h08 : i == 1 ? 8'h00 : 8'hB8);
      // Detector code as software must pick it for each mode
      wr(8'h02, i == 0 ? 8'hC1 : 8'hC3);
      pulse(1'b0);
      check_rf;
      pulse(1'b1);
      check_rf;
      rd(8'h02, opc_m);
    end
    // Ordinary reset keeps operation control, restores mode
    wr(8'h02, 8'hA5);
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    @(posedge core_clk_i);
    resetn_i <= 1'b1;
    mode_m = 8'h08;
    osc_m = 0;
    rd(8'h02, 8'hA5);
    rd(8'h03, 8'h08);
    repeat (6) @(posedge core_clk_i);
    osc_m = 1;
    check_rf;
    rd(8'h10, 8'h03);
    final_report;
  end
endmodule // nfcomc_top_test
`default_nettype wire
